// File: rtl/wiper_pkg.sv
// constants shared by the wiper stepper and its input qualifier
package wiper_pkg;

  // ----------------------------------------------------------------
  // clock and timebase
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned TICK_US     = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;

  // ----------------------------------------------------------------
  // wiper position
  // ----------------------------------------------------------------
  localparam int unsigned POS_W     = 6;
  localparam logic [5:0]  POS_MIN   = 6'h00;
  localparam logic [5:0]  POS_MAX   = 6'h3f;
  localparam int unsigned STORE_BIT = 3;

  // ----------------------------------------------------------------
  // times in ms, and their counts in timebase ticks
  // ----------------------------------------------------------------
  localparam int unsigned MS_W            = 12;
  localparam int unsigned PULSE_MIN_MS    = 1;
  localparam int unsigned GAP_MIN_MS      = 1;
  localparam int unsigned HOLD_MS         = 1000;
  localparam int unsigned REPEAT_MS       = 100;
  localparam int unsigned REVERSE_IDLE_MS = 1000;
  localparam int unsigned STORE_DELAY_MS  = 2000;

  // one extra tick covers the unknown phase of the first tick
  localparam logic [11:0] PULSE_TICKS   =
    MS_W'(PULSE_MIN_MS * 1000 / TICK_US + 1);
  localparam logic [11:0] GAP_TICKS     =
    MS_W'(GAP_MIN_MS * 1000 / TICK_US + 1);
  localparam logic [11:0] HOLD_TICKS    = MS_W'(HOLD_MS * 1000 / TICK_US);
  localparam logic [11:0] REPEAT_TICKS  = MS_W'(REPEAT_MS * 1000 / TICK_US);
  localparam logic [11:0] REVERSE_TICKS =
    MS_W'(REVERSE_IDLE_MS * 1000 / TICK_US + 1);
  localparam logic [11:0] STORE_TICKS   =
    MS_W'(STORE_DELAY_MS * 1000 / TICK_US);

  // ----------------------------------------------------------------
  // input channels and power-up sequence
  // ----------------------------------------------------------------
  localparam int unsigned N_CH        = 3;
  localparam int unsigned CH_UP       = 0;
  localparam int unsigned CH_DOWN     = 1;
  localparam int unsigned CH_STEP     = 2;
  localparam logic [1:0]  BOOT_CYCLES = 2'h3;

endpackage

// File: rtl/pulse_qualifier.sv
// one active-low control input: sync, pulse qualify, auto-repeat
`timescale 1ns/1ps

module pulse_qualifier (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // raw pin and millisecond tick
  input  wire logic pin_n,
  input  wire logic ms_tick,
  // qualified result
  output logic      step,
  output logic      busy
);
  import wiper_pkg::*;

  typedef enum logic [1:0] {IDLE, LOW, GAP} qual_state_t;

  logic              meta;
  logic              sync;
  qual_state_t       state;
  qual_state_t       next_state;
  logic [MS_W-1:0]   low_cnt;
  logic [MS_W-1:0]   next_low_cnt;
  logic [MS_W-1:0]   gap_cnt;
  logic [MS_W-1:0]   next_gap_cnt;
  logic [MS_W-1:0]   rep_cnt;
  logic [MS_W-1:0]   next_rep_cnt;
  logic              next_step;
  logic              active;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta <= 1'b1;
      sync <= 1'b1;
    end else begin
      meta <= pin_n;
      sync <= meta;
    end
  end

  assign active = ~sync; // RULE2

  // ----------------------------------------------------------------
  // pulse width and gap measurement
  // ----------------------------------------------------------------
  always_comb begin
    next_state   = state;
    next_low_cnt = low_cnt;
    next_gap_cnt = gap_cnt;
    next_rep_cnt = rep_cnt;
    next_step    = 1'b0;
    case (state)
      IDLE: begin
        if (active) begin // RULE2
          next_state   = LOW;
          next_low_cnt = '0;
          next_rep_cnt = '0;
        end
      end
      LOW: begin
        if (!active) begin
          next_state   = GAP;
          next_gap_cnt = '0;
        end else if (ms_tick) begin
          if (low_cnt != HOLD_TICKS) begin
            next_low_cnt = low_cnt + 1'b1; // RULE22
          end
          if (low_cnt + 1'b1 == PULSE_TICKS) begin
            next_step = 1'b1; // RULE3 RULE4
          end
          if (low_cnt == HOLD_TICKS) begin
            if (rep_cnt + 1'b1 == REPEAT_TICKS) begin
              next_rep_cnt = '0;
              next_step    = 1'b1; // RULE6
            end else begin
              next_rep_cnt = rep_cnt + 1'b1;
            end
          end
        end
      end
      GAP: begin
        // a short high spell merges into the same pulse; bounce too
        if (active) begin
          next_state = LOW; // RULE5 RULE16
        end else if (ms_tick) begin
          if (gap_cnt + 1'b1 == GAP_TICKS) begin
            next_state = IDLE; // RULE5
          end
          next_gap_cnt = gap_cnt + 1'b1;
        end
      end
      default: begin
        next_state = IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state   <= IDLE;
      low_cnt <= '0;
      gap_cnt <= '0;
      rep_cnt <= '0;
      step    <= 1'b0;
      busy    <= 1'b0;
    end else begin
      state   <= next_state;
      low_cnt <= next_low_cnt;
      gap_cnt <= next_gap_cnt;
      rep_cnt <= next_rep_cnt;
      step    <= next_step;
      busy    <= (next_state != IDLE);
    end
  end

endmodule

// File: rtl/wiper_stepper.sv
// pushbutton and processor controlled 64-tap wiper stepper
//
// Operation
// RULE1 - wiper is a 6-bit position holding one of 64 taps
// RULE2 - all control inputs are active low; a falling edge starts a pulse
// RULE3 - each qualifying single pulse moves the wiper by exactly one tap
// RULE4 - driver holds an input low over 1 ms, at most 1 s, per step
// RULE5 - pulses need 1 ms high between them, else they merge into one
// RULE6 - after a 1 s hold the wiper moves once every 100 ms
// RULE7 - single mode: up contact moves both ways, down contact is ignored
// RULE8 - single mode needs the down contact tied to supply at power-up
// RULE9 - floating down contact at power-up gives dual mode, kept until reset
// RULE10 - single mode starts moving opposite to the previous activity
// RULE11 - single mode reverses after over 1 s idle or at either end
// RULE12 - processor step input behaves like single pushbutton operation
// RULE13 - processor step input works in either pushbutton mode
// RULE14 - dual mode: up contact goes up, down contact goes down, no wait
// RULE15 - dual mode: wiper stays at an end until opposite input arrives
// RULE16 - contact inputs are debounced so bounce adds no steps
// RULE17 - outside logic drives down contact open drain, off at power-up
// RULE18 - at power-up the wiper loads the last stored position
// RULE19 - a changed position is written to storage after 2 s delay
// RULE20 - after the first store, store only when bit 3 changes
// RULE21 - stepping saturates at 0 and 63, never wrapping
// RULE22 - timing is measured from a free-running millisecond timebase
`timescale 1ns/1ps

module wiper_stepper #(
  parameter int unsigned TICK_CYCLES = wiper_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  // control pins, active low
  input  wire logic                        up_contact_in,
  input  wire logic                        down_contact_in,
  input  wire logic                        cpu_step_in,
  // power-up strap: high when the down contact is tied to supply
  input  wire logic                        down_tie_in,
  // nonvolatile store
  input  wire logic [wiper_pkg::POS_W-1:0] nv_word,
  output logic                             nv_write,
  output logic      [wiper_pkg::POS_W-1:0] nv_data,
  // wiper and mode
  output logic      [wiper_pkg::POS_W-1:0] wiper_pos,
  output logic                             single_mode
);
  import wiper_pkg::*;

  localparam int unsigned TICK_W = $clog2(TICK_CYCLES);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [N_CH-1:0]   pins_n;
  logic [N_CH-1:0]   ch_step;
  logic [N_CH-1:0]   ch_busy;

  logic [TICK_W-1:0] tick_cnt;
  logic [TICK_W-1:0] next_tick_cnt;
  logic              ms_tick;
  logic              next_ms_tick;

  logic              tie_meta;
  logic              tie_sync;
  logic [1:0]        boot_cnt;
  logic [1:0]        next_boot_cnt;
  logic              ready;
  logic              next_ready;
  logic              next_single_mode;

  logic [POS_W-1:0]  next_wiper_pos;
  logic              dir_up;
  logic              next_dir_up;
  logic              ended;
  logic              next_ended;
  logic [MS_W-1:0]   idle_cnt;
  logic [MS_W-1:0]   next_idle_cnt;
  logic              idle_done;
  logic              next_idle_done;

  logic              pending;
  logic              next_pending;
  logic              first_done;
  logic              next_first_done;
  logic [MS_W-1:0]   store_cnt;
  logic [MS_W-1:0]   next_store_cnt;
  logic              next_nv_write;
  logic [POS_W-1:0]  next_nv_data;

  logic              move;
  logic              move_up;
  logic              single_src;
  logic              single_busy;
  logic              at_top;
  logic              at_bottom;

  // ----------------------------------------------------------------
  // free-running millisecond timebase
  // ----------------------------------------------------------------
  always_comb begin
    next_tick_cnt = tick_cnt + 1'b1;
    next_ms_tick  = 1'b0;
    if (tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
      next_tick_cnt = '0;
      next_ms_tick  = 1'b1; // RULE22
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tick_cnt <= '0;
      ms_tick  <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      ms_tick  <= next_ms_tick;
    end
  end

  // ----------------------------------------------------------------
  // input channels
  // ----------------------------------------------------------------
  assign pins_n[CH_UP]   = up_contact_in;
  assign pins_n[CH_DOWN] = down_contact_in;
  assign pins_n[CH_STEP] = cpu_step_in;

  // bounce shorter than the gap window folds into one pulse
  for (genvar g = 0; g < N_CH; g++) begin : g_ch
    pulse_qualifier u_qual (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .pin_n   (pins_n[g]),
      .ms_tick (ms_tick),
      .step    (ch_step[g]),
      .busy    (ch_busy[g])
    ); // RULE16
  end

  // ----------------------------------------------------------------
  // power-up strap synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tie_meta <= 1'b0;
      tie_sync <= 1'b0;
    end else begin
      tie_meta <= down_tie_in;
      tie_sync <= tie_meta;
    end
  end

  // ----------------------------------------------------------------
  // step selection
  // ----------------------------------------------------------------
  assign at_top      = (wiper_pos == POS_MAX);
  assign at_bottom   = (wiper_pos == POS_MIN);
  assign single_busy = (single_mode & ch_busy[CH_UP]) | ch_busy[CH_STEP];

  // one move per cycle; simultaneous steps from two sources keep only
  // the first, which needs pulses starting within the same 1 ms timebase tick
  always_comb begin
    move       = 1'b0;
    move_up    = 1'b0;
    single_src = 1'b0;
    if (ready) begin
      if (ch_step[CH_UP] && !single_mode) begin
        move    = 1'b1;
        move_up = 1'b1; // RULE14
      end else if (ch_step[CH_DOWN] && !single_mode) begin
        move    = 1'b1;
        move_up = 1'b0; // RULE14
      end else if ((ch_step[CH_UP] && single_mode) || ch_step[CH_STEP]) begin
        move       = 1'b1; // RULE7 RULE12 RULE13
        single_src = 1'b1;
        // already parked at the end it heads for: turn first
        if (dir_up && at_top) begin
          move_up = 1'b0; // RULE11
        end else if (!dir_up && at_bottom) begin
          move_up = 1'b1; // RULE11
        end else begin
          move_up = dir_up; // RULE10
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // wiper, mode and direction
  // ----------------------------------------------------------------
  always_comb begin
    next_boot_cnt    = boot_cnt;
    next_ready       = ready;
    next_single_mode = single_mode;
    next_wiper_pos   = wiper_pos;
    next_dir_up      = dir_up;
    next_ended       = ended;
    next_idle_cnt    = idle_cnt;
    next_idle_done   = idle_done;
    if (!ready) begin
      next_boot_cnt = boot_cnt + 1'b1;
      if (boot_cnt == BOOT_CYCLES - 2'h1) begin
        next_ready       = 1'b1;
        next_single_mode = tie_sync; // RULE8 RULE9 RULE17
        next_wiper_pos   = nv_word; // RULE18
        next_dir_up      = (nv_word != POS_MAX);
      end
    end else begin
      if (move) begin
        if (move_up && !at_top) begin // RULE15
          next_wiper_pos = wiper_pos + 1'b1; // RULE3 RULE21
        end else if (!move_up && !at_bottom) begin // RULE15
          next_wiper_pos = wiper_pos - 1'b1; // RULE3 RULE21
        end
      end
      if (single_src) begin
        next_dir_up = move_up;
        next_ended  = 1'b0;
        // reaching an end turns round; idle must not turn it back
        if ((move_up && next_wiper_pos == POS_MAX) ||
            (!move_up && next_wiper_pos == POS_MIN)) begin
          next_dir_up = ~move_up; // RULE11
          next_ended  = 1'b1;
        end
      end
      if (single_busy) begin
        next_idle_cnt  = '0;
        next_idle_done = 1'b0;
      end else if (ms_tick && !idle_done) begin
        next_idle_cnt = idle_cnt + 1'b1;
        if (idle_cnt + 1'b1 == REVERSE_TICKS) begin
          next_idle_done = 1'b1;
          if (!ended) begin
            next_dir_up = ~dir_up; // RULE10 RULE11
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      boot_cnt    <= '0;
      ready       <= 1'b0;
      single_mode <= 1'b0;
      wiper_pos   <= POS_MIN; // RULE1
      dir_up      <= 1'b1;
      ended       <= 1'b0;
      idle_cnt    <= '0;
      idle_done   <= 1'b1;
    end else begin
      boot_cnt    <= next_boot_cnt;
      ready       <= next_ready;
      single_mode <= next_single_mode; // RULE9
      wiper_pos   <= next_wiper_pos;
      dir_up      <= next_dir_up;
      ended       <= next_ended;
      idle_cnt    <= next_idle_cnt;
      idle_done   <= next_idle_done;
    end
  end

  // ----------------------------------------------------------------
  // nonvolatile store policy
  // ----------------------------------------------------------------
  // after the first store, coarse changes only, to spare the limited write endurance
  always_comb begin
    next_pending    = pending;
    next_first_done = first_done;
    next_store_cnt  = store_cnt;
    next_nv_write   = 1'b0;
    next_nv_data    = nv_data;
    if (!ready) begin
      if (boot_cnt == BOOT_CYCLES - 2'h1) begin
        next_nv_data = nv_word;
      end
    end else if (next_wiper_pos != wiper_pos) begin
      if (!first_done ||
          next_wiper_pos[STORE_BIT] != nv_data[STORE_BIT]) begin
        next_pending   = 1'b1; // RULE20
        next_store_cnt = '0; // RULE19
      end
    end else if (pending && ms_tick) begin
      next_store_cnt = store_cnt + 1'b1;
      if (store_cnt + 1'b1 == STORE_TICKS) begin
        next_pending    = 1'b0;
        next_first_done = 1'b1;
        next_nv_write   = 1'b1; // RULE19
        next_nv_data    = wiper_pos;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pending    <= 1'b0;
      first_done <= 1'b0;
      store_cnt  <= '0;
      nv_write   <= 1'b0;
      nv_data    <= POS_MIN;
    end else begin
      pending    <= next_pending;
      first_done <= next_first_done;
      store_cnt  <= next_store_cnt;
      nv_write   <= next_nv_write;
      nv_data    <= next_nv_data;
    end
  end

endmodule

// File: test/wiper_stepper_properties.sv
// port assertions for the wiper stepper
`timescale 1ns/1ps

module wiper_stepper_properties #(
  parameter int unsigned TICK_CYCLES = 25000
) (
  // clock and reset
  input wire logic                        clk_sys,
  input wire logic                        sys_rst,
  // pins and strap
  input wire logic                        up_contact_in,
  input wire logic                        down_contact_in,
  input wire logic                        cpu_step_in,
  input wire logic                        down_tie_in,
  // store and wiper
  input wire logic [wiper_pkg::POS_W-1:0] nv_word,
  input wire logic                        nv_write,
  input wire logic [wiper_pkg::POS_W-1:0] nv_data,
  input wire logic [wiper_pkg::POS_W-1:0] wiper_pos,
  input wire logic                        single_mode
);
  import wiper_pkg::*;
  // ------
  // helpers
  // ------
  // store timer may start a tick early, so one tick of slack
  localparam int STORE_MIN = 1999 * TICK_CYCLES;
  logic [2:0]  cnt;
  logic [3:0]  hi_up;
  logic [3:0]  hi_dn;
  logic [3:0]  hi_cpu;
  logic [31:0] gap;
  wire booted  = cnt > 3'h4;
  wire no_down = hi_dn > 4'hb && hi_cpu > 4'hb;
  always_ff @(posedge clk_sys) begin
    cnt    <= sys_rst ? 3'h0 : cnt + 3'(cnt != 3'h7);
    gap    <= (sys_rst || nv_write) ? 32'h0 : gap + 32'h1;
    hi_up  <= (sys_rst || !up_contact_in) ? 4'h0 : hi_up + 4'(hi_up != 4'hf);
    hi_dn  <= (sys_rst || !down_contact_in) ? 4'h0 : hi_dn + 4'(hi_dn != 4'hf);
    hi_cpu <= (sys_rst || !cpu_step_in) ? 4'h0 : hi_cpu + 4'(hi_cpu != 4'hf);
  end
  // ------
  // properties
  // ------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence write_pulse;
    nv_write ##1 !nv_write;
  endsequence
  reset_vals_a:
  assert property ($fell(sys_rst) |-> wiper_pos == 6'h00 && !nv_write
    && nv_data == 6'h00 && !single_mode) else $error("reset values");
  boot_load_a:
  assert property (cnt == 3'h4 |-> wiper_pos == nv_word && nv_data == nv_word
    && single_mode == down_tie_in) else $error("boot load");
  mode_kept_a:
  assert property (booted |-> $stable(single_mode)) else $error("mode moved");
  step_size_a:
  assert property (booted && $changed(wiper_pos) |-> ({1'b0, wiper_pos}
    - {1'b0, $past(wiper_pos)}) inside {7'h01, 7'h7f}) else $error("step");
  nv_pulse_a:
  assert property (nv_write |-> nv_data == wiper_pos ##0 write_pulse)
    else $error("store pulse");
  store_gap_a:
  assert property (nv_write |-> gap >= STORE_MIN) else $error("store early");
  idle_still_a:
  assert property (booted && no_down && hi_up > 4'hb |-> $stable(wiper_pos))
    else $error("move while idle");
  single_ignore_a:
  assert property (single_mode && booted && hi_up > 4'hb && hi_cpu > 4'hb
    |-> $stable(wiper_pos)) else $error("down contact acted");
  up_dir_a:
  assert property (!single_mode && booted && no_down && $changed(wiper_pos)
    |-> wiper_pos > $past(wiper_pos)) else $error("up went down");
  end_hold_a:
  assert property (!single_mode && booted && no_down
    && $past(wiper_pos) == 6'h3f |-> wiper_pos == 6'h3f) else $error("end");
endmodule

bind wiper_stepper wiper_stepper_properties #(
  .TICK_CYCLES(TICK_CYCLES)
) props_i (
  .clk_sys        (clk_sys),
  .sys_rst        (sys_rst),
  .up_contact_in  (up_contact_in),
  .down_contact_in(down_contact_in),
  .cpu_step_in    (cpu_step_in),
  .down_tie_in    (down_tie_in),
  .nv_word        (nv_word),
  .nv_write       (nv_write),
  .nv_data        (nv_data),
  .wiper_pos      (wiper_pos),
  .single_mode    (single_mode)
);

// File: test/contact_model.sv
// pushbutton or processor output driving one active-low pin
`timescale 1ns/1ps

module contact_model (
  // clock
  input  wire logic clk_sys,
  // pin, pulled up when released
  output logic      pin_n
);
  initial pin_n = 1'b1;
  // b bounce toggles, n cycles low, then g cycles high
  task automatic press(input int n, input int b, input int g);
    for (int i = 0; i < b; i++) begin
      @(posedge clk_sys) pin_n <= 1'b0;
      @(posedge clk_sys) pin_n <= 1'b1;
    end
    @(posedge clk_sys) pin_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    pin_n <= 1'b1;
    repeat (g) @(posedge clk_sys);
  endtask
endmodule

// File: test/test_wiper_stepper.sv
// self-checking bench for the wiper stepper
`timescale 1ns/1ps

module test_wiper_stepper;
  import wiper_pkg::*;
  // ------
  // setup
  // ------
  // short ticks keep the second-long holds affordable
  localparam int TC = 10;
  logic             clk_sys     = 1'b0;
  logic             sys_rst     = 1'b1;
  logic             down_tie_in = 1'b0;
  logic [POS_W-1:0] nv_word     = 6'h00;
  wire              up_contact_in;
  wire              down_contact_in;
  wire              cpu_step_in;
  wire              nv_write;
  wire              single_mode;
  wire [POS_W-1:0]  nv_data;
  wire [POS_W-1:0]  wiper_pos;
  int               errors      = 0;
  int               n_tests     = 0;

  initial forever #20 clk_sys = ~clk_sys;

  contact_model up_btn (.clk_sys(clk_sys), .pin_n(up_contact_in));
  contact_model dn_btn (.clk_sys(clk_sys), .pin_n(down_contact_in));
  contact_model cpu_src (.clk_sys(clk_sys), .pin_n(cpu_step_in));

  wiper_stepper #(.TICK_CYCLES(TC)) wiper_stepper_i (
    .clk_sys        (clk_sys),
    .sys_rst        (sys_rst),
    .up_contact_in  (up_contact_in),
    .down_contact_in(down_contact_in),
    .cpu_step_in    (cpu_step_in),
    .down_tie_in    (down_tie_in),
    .nv_word        (nv_word),
    .nv_write       (nv_write),
    .nv_data        (nv_data),
    .wiper_pos      (wiper_pos),
    .single_mode    (single_mode)
  );
  // ------
  // tasks
  // ------
  task automatic check(input logic [5:0] got, input logic [5:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic expect_pos(input logic [5:0] exp);
    @(negedge clk_sys);
    check(wiper_pos, exp);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic power_up(input logic [5:0] word, input logic tie);
    @(posedge clk_sys);
    sys_rst     <= 1'b1;
    nv_word     <= word;
    down_tie_in <= tie;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    expect_pos(word);
    check({5'h0, single_mode}, {5'h0, tie});
  endtask

  // a store runs out its bound when it is not due
  task automatic wait_store(input logic want, input logic [5:0] exp);
    for (int i = 0; i < 2100 * TC && nv_write !== 1'b1; i++)
      @(negedge clk_sys);
    check({5'h0, nv_write}, {5'h0, want});
    if (want && nv_write !== 1'b1) wrap_up();
    if (want) check(nv_data, exp);
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_dual();
    power_up(6'h07, 1'b0);
    up_btn.press(50, 0, 40);
    expect_pos(6'h08);
    dn_btn.press(50, 0, 0);
    expect_pos(6'h07);
    up_btn.press(50, 0, 40);
    expect_pos(6'h08);
    up_btn.press(4, 0, 40);
    expect_pos(6'h08);
    up_btn.press(50, 3, 40);
    expect_pos(6'h09);
    up_btn.press(15, 0, 4);
    up_btn.press(15, 0, 40);
    expect_pos(6'h0a);
    cpu_src.press(50, 0, 40);
    expect_pos(6'h0b);
    $display("test dual done");
  endtask

  task automatic t_store();
    wait_store(1'b1, 6'h0b);
    dn_btn.press(50, 0, 40);
    expect_pos(6'h0a);
    wait_store(1'b0, 6'h0a);
    $display("test store done");
  endtask

  task automatic t_repeat();
    up_btn.press(1250 * TC, 0, 40);
    expect_pos(6'h0d);
    $display("test repeat done");
  endtask

  task automatic t_end();
    power_up(6'h3f, 1'b0);
    up_btn.press(50, 0, 40);
    expect_pos(6'h3f);
    dn_btn.press(50, 0, 40);
    expect_pos(6'h3e);
    $display("test end done");
  endtask

  task automatic t_single();
    power_up(6'h3f, 1'b1);
    up_btn.press(50, 0, 40);
    expect_pos(6'h3e);
    dn_btn.press(50, 0, 40);
    expect_pos(6'h3e);
    cpu_src.press(50, 0, 40);
    expect_pos(6'h3d);
    repeat (1010 * TC) @(posedge clk_sys);
    up_btn.press(50, 0, 40);
    expect_pos(6'h3e);
    up_btn.press(50, 0, 40);
    expect_pos(6'h3f);
    up_btn.press(50, 0, 40);
    expect_pos(6'h3e);
    $display("test single done");
  endtask

  initial begin
    t_dual();
    t_store();
    t_repeat();
    t_end();
    t_single();
    wrap_up();
  end
endmodule
